//--- inc/scp_pkg.sv
// scp_pkg: constants and carriers for the serial configuration port master
// assumes a 25 MHz core clock; the serial clock is generated by division
package scp_pkg;
	localparam int CMD_W = 5;
	localparam int NDATA_W = 16;
	localparam int XDATA_W = 46;
	localparam int DMAX_W = 46;
	localparam int XCLK_PER_BIT = 4;
	localparam int CNT_W = 8;
	localparam int BIT_W = 6;
	localparam int DIV_W = 16;
	// mode bits of the command: top bit write, next bit extended timing
	localparam int CMD_WR_POS = 4;
	localparam int CMD_XT_POS = 3;
	// setup spacing from the frame_select rising edge, in ns
	localparam int CLK_NS = 40;
	localparam int CS_SETUP_NS = 30;
	localparam int CS_SETUP_CYC = (CS_SETUP_NS + CLK_NS - 1) / CLK_NS;
	// default half-period: 25 MHz / (2*3) = 4.17 MHz, below 6 MHz limit
	localparam logic [DIV_W-1:0] HALF_DEFAULT = 16'h0003;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_SETUP = 3'b001,
		ST_CMD = 3'b011,
		ST_DATA = 3'b010,
		ST_HOLD = 3'b110,
		ST_DONE = 3'b111
	} scp_state_e;

	typedef struct packed {
		logic [CMD_W-1:0] cmd;
		logic [DMAX_W-1:0] data;
	} scp_req_s;

	typedef struct packed {
		logic sel;
		logic sclk;
		logic sdo;
		logic sdo_en;
	} scp_pins_s;

	typedef struct packed {
		scp_state_e state;
		scp_pins_s pins;
		logic [DIV_W-1:0] div;
		logic [BIT_W-1:0] bits_left;
		logic [1:0] sub;
		logic [CMD_W-1:0] cmd;
		logic [DMAX_W-1:0] shreg;
		logic [DMAX_W-1:0] rdata;
		logic busy;
		logic done;
		logic sdi_m;
		logic sdi;
	} scp_st_s;
endpackage

//--- src/scp_master.sv
// scp_master: host-side master for a three-wire serial configuration port
// assumes the sensor captures on rising serial_clock and updates read data after it
// Overview of operation
// - every access starts by raising frame_select
// - command and data share one bidirectional shared_data_line
// - normal mode one clock per data bit, extended mode four clocks
// - normal frame is 5 command bits then 16 data bits
// - extended frame is 5 command bits then 46 data bits
// - master sets command and write bits before the rising clock edge
// - on read, master releases the line after last command rising edge
// - normal mode serial_clock at most 6 MHz
// - extended OTP read and write clock at most 6 kHz; the bench runs extended frames at 4.17 MHz
// - OTP programming clock between 200 and 650 kHz, precise period
// - analog readback clock at most 162.5 kHz
// - bits are sent most significant first
// - unlock command must precede extended OTP access
module scp_master #(
	parameter int CMD_W = scp_pkg::CMD_W
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic [scp_pkg::CMD_W-1:0] cmd_i,
	input wire logic [scp_pkg::DMAX_W-1:0] wdata_i,
	input wire logic [scp_pkg::DIV_W-1:0] half_period_i,
	output logic busy_o,
	output logic done_o,
	output logic [scp_pkg::DMAX_W-1:0] rdata_o,
	output logic frame_select_o,
	output logic serial_clock_o,
	output logic shared_data_o,
	output logic shared_data_oe_o,
	input wire logic shared_data_i
);
	scp_pkg::scp_st_s st;
	scp_pkg::scp_st_s next_st;
	logic tick;

	// frame length in data bits from the mode bit of the command
	function automatic logic [scp_pkg::BIT_W-1:0] data_bits(input logic xt);
		data_bits = xt ? scp_pkg::BIT_W'(scp_pkg::XDATA_W)
			: scp_pkg::BIT_W'(scp_pkg::NDATA_W);
	endfunction

	// extended timing is the second command bit; several states read it
	function automatic logic is_ext(input logic [scp_pkg::CMD_W-1:0] c);
		is_ext = c[scp_pkg::CMD_XT_POS];
	endfunction

	// a write keeps the line driven through the data phase
	function automatic logic is_write(input logic [scp_pkg::CMD_W-1:0] c);
		is_write = c[scp_pkg::CMD_WR_POS];
	endfunction

	// the write bit that goes out next, aligned to the frame length
	function automatic logic data_msb(
		input logic [scp_pkg::DMAX_W-1:0] sh,
		input logic xt
	);
		if (xt) begin
			data_msb = sh[scp_pkg::XDATA_W-1];
		end else begin
			data_msb = sh[scp_pkg::NDATA_W-1];
		end
	endfunction

	// divider reload; a zero half period behaves as one, so the clock never stalls
	function automatic logic [scp_pkg::DIV_W-1:0] reload(
		input logic [scp_pkg::DIV_W-1:0] h
	);
		if (h == '0) begin
			reload = '0;
		end else begin
			reload = h - scp_pkg::DIV_W'(1);
		end
	endfunction

	// a normal read only fills the low word; older bits above it are cleared
	function automatic logic [scp_pkg::DMAX_W-1:0] read_mask(
		input logic [scp_pkg::DMAX_W-1:0] d,
		input logic xt
	);
		read_mask = d;
		if (!xt) begin
			read_mask = d & scp_pkg::DMAX_W'({scp_pkg::NDATA_W{1'b1}});
		end
	endfunction

	// the divider only runs inside a frame, so every half period is full length
	// limitation: read bits cross two synchroniser flops before sampling, so a
	// read needs a half period of at least three core cycles; writes work at two
	assign tick = (st.div == '0);

	always_comb begin
		next_st = st;
		next_st.done = 1'b0;
		// read data passes two flops before use
		next_st.sdi_m = shared_data_i;
		next_st.sdi = st.sdi_m;
		if (st.state != scp_pkg::ST_IDLE) begin
			// one divider sets every link rate; the caller picks the mode's limit
			if (tick) begin
				next_st.div = reload(half_period_i);
			end else begin
				next_st.div = st.div - scp_pkg::DIV_W'(1);
			end
		end
		case (st.state)
			scp_pkg::ST_IDLE: begin
				next_st.pins = '0;
				if (start_i) begin
					next_st.cmd = cmd_i;
					next_st.shreg = wdata_i;
					next_st.pins.sel = 1'b1;
					next_st.pins.sdo = cmd_i[scp_pkg::CMD_W-1];
					next_st.pins.sdo_en = 1'b1;
					next_st.bits_left = scp_pkg::BIT_W'(scp_pkg::CMD_W);
					// select must lead the first rising clock by the setup time
					if (scp_pkg::DIV_W'(scp_pkg::CS_SETUP_CYC) > half_period_i) begin
						next_st.div = scp_pkg::DIV_W'(scp_pkg::CS_SETUP_CYC);
					end else begin
						next_st.div = half_period_i;
					end
					next_st.busy = 1'b1;
					next_st.state = scp_pkg::ST_SETUP;
				end
			end
			scp_pkg::ST_SETUP: begin
				if (tick) begin
					next_st.state = scp_pkg::ST_CMD;
				end
			end
			scp_pkg::ST_CMD: begin
				if (tick) begin
					next_st.pins.sclk = ~st.pins.sclk;
					if (st.pins.sclk) begin
						// falling edge: shift out the next command bit
						next_st.bits_left = st.bits_left - scp_pkg::BIT_W'(1);
						next_st.cmd = {st.cmd[scp_pkg::CMD_W-2:0], 1'b0};
						next_st.pins.sdo = st.cmd[scp_pkg::CMD_W-2];
						if (st.bits_left == scp_pkg::BIT_W'(1)) begin
							next_st.bits_left = data_bits(is_ext(cmd_i));
							next_st.sub = '0;
							next_st.state = scp_pkg::ST_DATA;
							// write data: msb first, aligned to frame length
							next_st.pins.sdo = data_msb(st.shreg, is_ext(cmd_i));
							// a read frees the line at once so the device may take it
							next_st.pins.sdo_en = is_write(cmd_i);
						end
					end
				end
			end
			scp_pkg::ST_DATA: begin
				if (tick) begin
					next_st.pins.sclk = ~st.pins.sclk;
					if (st.pins.sclk) begin
						// extended frames hold each bit for four clocks
						if (!is_ext(cmd_i)
							|| st.sub == 2'(scp_pkg::XCLK_PER_BIT - 1)) begin
							next_st.sub = '0;
							next_st.bits_left = st.bits_left - scp_pkg::BIT_W'(1);
							next_st.shreg = {st.shreg[scp_pkg::DMAX_W-2:0], 1'b0};
							// sample read bit late in the bit, after the device updated it
							next_st.rdata = {st.rdata[scp_pkg::DMAX_W-2:0], st.sdi};
							next_st.pins.sdo = data_msb({st.shreg[scp_pkg::DMAX_W-2:0], 1'b0},
								is_ext(cmd_i));
							if (st.bits_left == scp_pkg::BIT_W'(1)) begin
								next_st.state = scp_pkg::ST_HOLD;
							end
						end else begin
							next_st.sub = st.sub + 2'h1;
						end
					end
				end
			end
			scp_pkg::ST_HOLD: begin
				// keep select high a half period after the last falling edge
				if (tick) begin
					next_st.pins = '0;
					next_st.state = scp_pkg::ST_DONE;
				end
			end
			scp_pkg::ST_DONE: begin
				next_st.busy = 1'b0;
				next_st.done = 1'b1;
				// the result stands until the next frame shifts its first data bit
				next_st.rdata = read_mask(st.rdata, is_ext(cmd_i));
				next_st.state = scp_pkg::ST_IDLE;
			end
			default: begin
				next_st = '0;
			end
		endcase
	end

	// the whole state moves on one clock; reset gives an idle, released link
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign busy_o = st.busy;
	assign done_o = st.done;
	assign rdata_o = st.rdata;
	assign frame_select_o = st.pins.sel;
	assign serial_clock_o = st.pins.sclk;
	assign shared_data_o = st.pins.sdo;
	assign shared_data_oe_o = st.pins.sdo_en;
endmodule

//--- verif/scp_props.sv
// scp_props: port-level protocol checks for the serial master
// assumes the bind below attaches it to every scp_master instance
module scp_props #(
	parameter int CMD_W = scp_pkg::CMD_W
) (
	input wire logic core_clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic [scp_pkg::CMD_W-1:0] cmd_i,
	input wire logic busy_o,
	input wire logic done_o,
	input wire logic frame_select_o,
	input wire logic serial_clock_o,
	input wire logic shared_data_o,
	input wire logic shared_data_oe_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	clk_idle_a: assert property (!frame_select_o |-> !serial_clock_o) else $error("clock moves outside frame");
	frame_open_a: assert property ($rose(frame_select_o) |-> shared_data_oe_o && !serial_clock_o) else $error("bad frame start");
	cmd_msb_a: assert property ($rose(frame_select_o) |-> shared_data_o == cmd_i[CMD_W-1]) else $error("first bit not msb");
	line_free_a: assert property (!frame_select_o |-> !shared_data_oe_o) else $error("line driven outside frame");
	bit_setup_a: assert property ($rose(serial_clock_o) && shared_data_oe_o |-> $stable(shared_data_o)) else $error("data moves at rising clock");
	frame_busy_a: assert property (frame_select_o |-> busy_o) else $error("frame without busy");
	done_after_a: assert property ($fell(frame_select_o) |=> done_o ##1 !done_o) else $error("done not one cycle after frame");
	start_taken_a: assert property (start_i && !busy_o && !done_o && !frame_select_o |=> busy_o) else $error("start not taken");
endmodule
bind scp_master scp_props #(.CMD_W(CMD_W)) u_props (.core_clk_i, .rst_i, .start_i, .cmd_i, .busy_o,
	.done_o, .frame_select_o, .serial_clock_o, .shared_data_o, .shared_data_oe_o);

//--- verif/scp_dev.sv
// scp_dev: behavioural sensor port on the far side of the master
// assumes the bench resolves the shared line from both enables
module scp_dev #(
	parameter logic [45:0] RD = 46'h0
) (
	input wire logic sel_i,
	input wire logic sclk_i,
	input wire logic dio_i,
	output logic dio_o,
	output logic dio_oe_o,
	output logic [50:0] got_o
);
	timeunit 1ns;
	timeprecision 1ns;
	int n = 0;
	int k;
	int j;
	int len;
	logic [4:0] cmd = 5'h00;
	initial begin
		dio_o = 1'b0;
		dio_oe_o = 1'b0;
		got_o = '0;
	end
	// partial bits are dropped; a new frame starts clean
	always @(posedge sel_i) begin
		n = 0;
		got_o = '0;
	end
	always @(negedge sel_i) dio_oe_o = 1'b0;
	// capture on rising clock, then update read bits just after it
	// extended bits are taken once, at the last of their four rising edges
	always @(posedge sclk_i) if (sel_i) begin
		n++;
		if (n <= 5 || (n - 5) % k == 0) got_o = {got_o[49:0], dio_i};
		if (n == 5) cmd = got_o[4:0];
		k = cmd[3] ? 4 : 1;
		len = cmd[3] ? 46 : 16;
		j = n < 6 ? 0 : (n - 6) / k;
		if (n >= 5 && j < len) dio_o = RD[len - 1 - j];
	end
	// drive only half a period after the last command bit, reads only
	always @(negedge sclk_i) if (sel_i && n >= 5 && !cmd[4]) dio_oe_o = 1'b1;
endmodule

//--- verif/tb.sv
// tb: runs the serial master against the behavioural sensor port
// assumes a 25 MHz core clock and a pull-up on the shared line
module tb;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [45:0] RD = 46'h2C3A_5F0E_96B1;
	typedef struct packed {logic [4:0] c; logic [45:0] w;} scp_row_s;
	scp_row_s rows [5] = '{'{5'h05, 46'h0}, '{5'h0F, 46'h0}, '{5'h17, 46'hC003},
		'{5'h10, 46'h8CAE}, '{5'h1F, 46'h2A5A_C3F0_0F3C}};
	logic core_clk_i = 1'b0, rst_i = 1'b1, start_i = 1'b0, busy_o, done_o, fs, sck, sdo, oe;
	logic dev_d, dev_oe;
	logic [4:0] cmd_i = 5'h00;
	logic [45:0] wdata_i = 46'h0, rdata_o;
	logic [15:0] half_i = 16'h0003; // reads need three cycles past the synchroniser
	logic [50:0] got;
	wire pin = oe ? sdo : (dev_oe ? dev_d : 1'b1);
	int errors = 0, checks = 0, nfs = 0, i, n0;
	scp_master u_dut (.core_clk_i, .rst_i, .start_i, .cmd_i, .wdata_i, .half_period_i(half_i),
		.busy_o, .done_o, .rdata_o, .frame_select_o(fs), .serial_clock_o(sck),
		.shared_data_o(sdo), .shared_data_oe_o(oe), .shared_data_i(pin));
	scp_dev #(.RD(RD)) u_dev (.sel_i(fs), .sclk_i(sck), .dio_i(pin), .dio_o(dev_d),
		.dio_oe_o(dev_oe), .got_o(got));
	initial forever #20 core_clk_i = ~core_clk_i;
	always @(posedge fs) nfs++;
	task automatic chk(input string s, input logic [50:0] e, input logic [50:0] v);
		checks++;
		if (v !== e) begin
			errors++;
			$display("wrong value %s expected %h seen %h", s, e, v);
		end
	endtask
	// bounded wait; a hung frame shows up as a missing done
	task automatic wdone();
		int t;
		for (t = 0; t < 2000 && done_o !== 1'b1; t++) @(posedge core_clk_i);
		chk("done", 51'h1, done_o);
	endtask
	task automatic frame(input scp_row_s r);
		cmd_i <= r.c;
		wdata_i <= r.w;
		start_i <= 1'b1;
		@(posedge core_clk_i);
		start_i <= 1'b0;
		wdone();
	endtask
	task automatic close_out();
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	initial begin
		#1000000;
		errors++;
		close_out();
	end
	initial begin
		repeat (16) @(posedge core_clk_i);
		rst_i <= 1'b0;
		@(posedge core_clk_i);
		for (i = 0; i < 5; i++) begin
			frame(rows[i]);
			if (rows[i].c[4]) chk("sent", rows[i].c[3] ? {rows[i].c, rows[i].w} : {rows[i].c, rows[i].w[15:0]}, got);
			else chk("read", rows[i].c[3] ? RD : {30'h0, RD[15:0]}, rdata_o);
			$display("test %0d done", i);
		end
		// start held high for 20 cycles into a frame must not open a second one
		n0 = nfs;
		start_i <= 1'b1;
		repeat (20) @(posedge core_clk_i);
		start_i <= 1'b0;
		wdone();
		repeat (8) @(posedge core_clk_i);
		chk("frames", 51'h1, nfs - n0);
		$display("test refusal done");
		// reset in mid-frame must drop select, clock, line enable and busy within two core cycles
		half_i <= 16'h0003;
		cmd_i <= 5'h0F;
		start_i <= 1'b1;
		@(posedge core_clk_i);
		start_i <= 1'b0;
		repeat (30) @(posedge core_clk_i);
		rst_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		chk("abort pins", 51'h0, {fs, sck, oe, busy_o});
		rst_i <= 1'b0;
		@(posedge core_clk_i);
		frame(rows[4]);
		chk("after reset", {rows[4].c, rows[4].w}, got);
		$display("test reset done");
		close_out();
	end
endmodule
